// >>> design/smp_ctrl.sv
// protect, sleep and hold control of an spi nonvolatile memory
// assumes pins asynchronous to i_clock; array itself lives outside
// Summary of operation
// - sleep opcode then chip select rising enters sleep
// - any clock pulse after sleep opcode before deselect cancels sleep
// - asleep: clock and data ignored, data output floats
// - chip select fall wakes; normal operation within 400 us
// - block bits protect none, upper quarter, upper half, or all
// - latch clear blocks all writes; status protect with pin low blocks status
// - hold low while selected suspends command, progress kept
// - hold starts at once; hold end waits for the clock level seen at hold start
// - during hold inputs ignored, output floats for reads
// - deselect during hold aborts the command
// - abort before recognition keeps latch value
// - sleep opcode is b9 hex, msb first
// - latch cleared on wake, power-on, write-disable command
// - block bits at 3 and 2, status protect at 7, retained
`timescale 1ns/10ps
`default_nettype none
module smp_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // spi pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  // nonvolatile status image loaded at power-up
  input wire logic [7:0] i_nv_status,
  // memory array side
  input wire logic [7:0] i_mem_rdata,
  output logic [13:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  // status and state
  output logic [7:0] o_status,
  output logic o_asleep,
  output logic o_held
);
  smp_pkg::smp_link_s link;
  smp_pkg::smp_perm_s perm;
  smp_pkg::smp_cmd_e cmd_ff;
  smp_pkg::smp_pwr_e pwr_ff;
  logic [7:0] status_ff;
  logic nv_loaded_ff;
  logic [7:0] op_ff;
  logic [7:0] shift_ff;
  logic [4:0] bitcnt_ff;
  logic [15:0] addr_ff;
  logic [7:0] rd_ff;
  logic sleep_pend_ff;
  logic hold_ff;
  logic hold_lvl_ff;
  logic wel_saved_ff;
  logic [smp_pkg::WAKE_CNT_W-1:0] wake_cnt_ff;
  logic so_ff;
  logic so_oe_ff;
  logic mem_we_ff;
  logic mem_re_ff;
  logic wr_step_ff;
  logic [7:0] mem_wdata_ff;
  logic [7:0] nxt_shift;
  logic active;
  logic sck_rise;
  logic sck_fall;

  smp_sync u_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pins({i_cs_n, i_sck, i_si, i_hold_n, i_wp_n}),
    .o_link(link)
  );

  smp_perm u_perm (
    .i_status(status_ff),
    .i_wp_n(link.wp_n),
    .i_addr(addr_ff[13:0]),
    .o_perm(perm)
  );

  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == smp_pkg::OP_STATUS_READ_COMMAND) || (op == smp_pkg::OP_READ);
  endfunction

  // ************************************************************
  // qualified clock edges
  // ************************************************************
  // edges count only when selected, awake and not held
  assign active = !link.cs_n && (pwr_ff == smp_pkg::PWR_ACTIVE) && !hold_ff;
  assign sck_rise = active && link.sck_rise;
  assign sck_fall = active && link.sck_fall;
  assign nxt_shift = {shift_ff[6:0], link.si};

  // ************************************************************
  // hold state
  // ************************************************************
  // entry is at once; exit waits for the clock level seen at entry,
  // so a host obeying the release level never sees a split edge
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_ff <= 1'b0;
      hold_lvl_ff <= 1'b0;
    end else if (link.cs_n) begin
      hold_ff <= 1'b0;
    end else if (!hold_ff && !link.hold_n) begin
      hold_ff <= 1'b1;
      hold_lvl_ff <= link.sck;
    end else if (hold_ff && link.hold_n && link.sck == hold_lvl_ff) begin
      hold_ff <= 1'b0;
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_ff <= smp_pkg::CMD_OPCODE;
      op_ff <= 8'h00;
      shift_ff <= 8'h00;
      bitcnt_ff <= 5'h00;
      addr_ff <= 16'h0000;
    end else if (link.cs_n || pwr_ff != smp_pkg::PWR_ACTIVE) begin
      cmd_ff <= smp_pkg::CMD_OPCODE;
      bitcnt_ff <= 5'h00;
    end else if (sck_rise) begin
      shift_ff <= nxt_shift;
      bitcnt_ff <= bitcnt_ff + 5'h01;
      unique case (cmd_ff)
        smp_pkg::CMD_OPCODE: begin
          if (bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)) begin
            op_ff <= nxt_shift;
            bitcnt_ff <= 5'h00;
            if (nxt_shift == smp_pkg::OP_READ || nxt_shift == smp_pkg::OP_WRITE) begin
              cmd_ff <= smp_pkg::CMD_ADDR;
            end else if (nxt_shift == smp_pkg::OP_STATUS_WRITE_COMMAND) begin
              cmd_ff <= smp_pkg::CMD_DATA;
            end else if (nxt_shift == smp_pkg::OP_STATUS_READ_COMMAND) begin
              cmd_ff <= smp_pkg::CMD_READ;
            end else begin
              cmd_ff <= smp_pkg::CMD_DONE;
            end
          end
        end
        smp_pkg::CMD_ADDR: begin
          addr_ff <= {addr_ff[14:0], link.si};
          if (bitcnt_ff == 5'(smp_pkg::ADDR_BITS - 1)) begin
            bitcnt_ff <= 5'h00;
            cmd_ff <= (op_ff == smp_pkg::OP_READ) ? smp_pkg::CMD_READ : smp_pkg::CMD_DATA;
          end
        end
        smp_pkg::CMD_DATA: begin
          if (bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)) begin
            bitcnt_ff <= 5'h00;
            if (op_ff != smp_pkg::OP_WRITE) begin
              cmd_ff <= smp_pkg::CMD_DONE;
            end
          end
        end
        smp_pkg::CMD_READ: begin
          if (bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)) begin
            bitcnt_ff <= 5'h00;
            if (op_ff == smp_pkg::OP_READ) begin
              addr_ff <= addr_ff + 16'h0001;
            end
          end
        end
        smp_pkg::CMD_DONE: bitcnt_ff <= 5'h00;
        default: cmd_ff <= smp_pkg::CMD_DONE;
      endcase
    end else if (wr_step_ff) begin
      // step after the strobe cycle so the array sees the written address
      addr_ff <= addr_ff + 16'h0001;
    end
  end

  // ************************************************************
  // status register and write-enable latch
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      status_ff <= smp_pkg::STAT_RESET;
      nv_loaded_ff <= 1'b0;
      wel_saved_ff <= 1'b0;
    end else if (!nv_loaded_ff) begin
      // retained bits caught after reset release; latch stays clear
      nv_loaded_ff <= 1'b1;
      status_ff <= i_nv_status & smp_pkg::STAT_WRITABLE;
    end else begin
      if (!hold_ff && !link.hold_n && !link.cs_n) begin
        wel_saved_ff <= status_ff[smp_pkg::STAT_WEL_POS];
      end
      if (link.cs_rise && hold_ff && cmd_ff == smp_pkg::CMD_OPCODE) begin
        status_ff[smp_pkg::STAT_WEL_POS] <= wel_saved_ff;
      end else if (link.cs_fall && pwr_ff == smp_pkg::PWR_SLEEP) begin
        status_ff[smp_pkg::STAT_WEL_POS] <= 1'b0;
      end else if (sck_rise && cmd_ff == smp_pkg::CMD_OPCODE &&
                   bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)) begin
        if (nxt_shift == smp_pkg::OP_WREN) begin
          status_ff[smp_pkg::STAT_WEL_POS] <= 1'b1;
        end else if (nxt_shift == smp_pkg::OP_WRITE_DISABLE_COMMAND) begin
          status_ff[smp_pkg::STAT_WEL_POS] <= 1'b0;
        end
      end else if (sck_rise && cmd_ff == smp_pkg::CMD_DATA && op_ff == smp_pkg::OP_STATUS_WRITE_COMMAND &&
                   bitcnt_ff == 5'(smp_pkg::OP_BITS - 1) && perm.stat_ok) begin
        // latch and bit 0 are not writable through the status path
        status_ff <= (nxt_shift & smp_pkg::STAT_WRITABLE) |
                     (status_ff & ~smp_pkg::STAT_WRITABLE);
      end
    end
  end

  // ************************************************************
  // memory write and read strobes
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      wr_step_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end else begin
      wr_step_ff <= sck_rise && cmd_ff == smp_pkg::CMD_DATA && op_ff == smp_pkg::OP_WRITE &&
                    bitcnt_ff == 5'(smp_pkg::OP_BITS - 1);
      mem_we_ff <= sck_rise && cmd_ff == smp_pkg::CMD_DATA && op_ff == smp_pkg::OP_WRITE &&
                   bitcnt_ff == 5'(smp_pkg::OP_BITS - 1) && perm.mem_ok;
      mem_re_ff <= sck_rise && op_ff == smp_pkg::OP_READ &&
                   ((cmd_ff == smp_pkg::CMD_ADDR && bitcnt_ff == 5'(smp_pkg::ADDR_BITS - 1)) ||
                    (cmd_ff == smp_pkg::CMD_READ && bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)));
      if (sck_rise && cmd_ff == smp_pkg::CMD_DATA) begin
        mem_wdata_ff <= nxt_shift;
      end
    end
  end

  // ************************************************************
  // serial data output
  // ************************************************************
  // read data loads on each byte boundary, shifts out on falling clock
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ff <= 8'h00;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= active && cmd_ff == smp_pkg::CMD_READ && is_read_op(op_ff);
      if (mem_re_ff) begin
        rd_ff <= i_mem_rdata;
      end else if (sck_fall && cmd_ff == smp_pkg::CMD_READ) begin
        if (bitcnt_ff == 5'h00 && op_ff == smp_pkg::OP_STATUS_READ_COMMAND) begin
          so_ff <= status_ff[7];
          rd_ff <= {status_ff[6:0], 1'b0};
        end else begin
          so_ff <= rd_ff[7];
          rd_ff <= {rd_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ************************************************************
  // sleep entry, cancel and wake recovery
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_ff <= smp_pkg::PWR_ACTIVE;
      sleep_pend_ff <= 1'b0;
      wake_cnt_ff <= '0;
    end else begin
      unique case (pwr_ff)
        smp_pkg::PWR_ACTIVE: begin
          if (link.cs_rise) begin
            sleep_pend_ff <= 1'b0;
            if (sleep_pend_ff && !hold_ff) begin
              pwr_ff <= smp_pkg::PWR_SLEEP;
            end
          end else if (sck_rise && cmd_ff == smp_pkg::CMD_OPCODE &&
                       bitcnt_ff == 5'(smp_pkg::OP_BITS - 1)) begin
            sleep_pend_ff <= (nxt_shift == smp_pkg::OP_SLEEP);
          end else if (sck_rise) begin
            sleep_pend_ff <= 1'b0;
          end
        end
        smp_pkg::PWR_SLEEP: begin
          if (link.cs_fall) begin
            pwr_ff <= smp_pkg::PWR_WAKE;
            wake_cnt_ff <= smp_pkg::WAKE_CNT_W'(smp_pkg::WAKE_RECOVERY_CYC - 1);
          end
        end
        smp_pkg::PWR_WAKE: begin
          // host keeps chip select from falling again until done
          if (wake_cnt_ff == '0) begin
            pwr_ff <= smp_pkg::PWR_ACTIVE;
          end else begin
            wake_cnt_ff <= wake_cnt_ff - smp_pkg::WAKE_CNT_W'(1);
          end
        end
        default: pwr_ff <= smp_pkg::PWR_ACTIVE;
      endcase
    end
  end

  assign o_so = so_ff;
  assign o_so_oe = so_oe_ff;
  assign o_mem_addr = addr_ff[13:0];
  assign o_mem_wdata = mem_wdata_ff;
  assign o_mem_we = mem_we_ff;
  assign o_mem_re = mem_re_ff;
  assign o_status = status_ff;
  // sleep and wake codes share bit 0, so the flag is a flop bit
  assign o_asleep = pwr_ff[0];
  assign o_held = hold_ff;
endmodule
`default_nettype wire

// >>> design/smp_perm.sv
// write permission decision from latch, status protect, pin and block bits
// assumes all inputs are on i_clock domain; purely combinational
`timescale 1ns/10ps
`default_nettype none
module smp_perm (
  // status and pin
  input wire logic [7:0] i_status,
  input wire logic i_wp_n,
  // target address
  input wire logic [13:0] i_addr,
  // decision
  output var smp_pkg::smp_perm_s o_perm
);
  logic write_enable_latch;
  logic spe;
  logic [1:0] bp;
  logic in_prot;

  always_comb begin
    write_enable_latch = i_status[smp_pkg::STAT_WEL_POS];
    spe = i_status[smp_pkg::STAT_SPE_POS];
    bp = {i_status[smp_pkg::STAT_BPH_POS], i_status[smp_pkg::STAT_BPL_POS]};
    unique case (bp)
      2'b00: in_prot = 1'b0;
      2'b01: in_prot = i_addr >= smp_pkg::QUARTER_BASE;
      2'b10: in_prot = i_addr >= smp_pkg::HALF_BASE;
      2'b11: in_prot = 1'b1;
    endcase
    o_perm.mem_ok = write_enable_latch & ~in_prot;
    o_perm.stat_ok = write_enable_latch & ~(spe & ~i_wp_n);
  end
endmodule
`default_nettype wire

// >>> design/smp_pkg.sv
// constants and carriers for the spi memory protect/sleep/hold control block
// assumes nothing beyond a systemverilog compiler; no module lives here
package smp_pkg;
  // ************************************************************
  // opcodes and status layout
  // ************************************************************
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_COMMAND = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_COMMAND = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_COMMAND = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam int STAT_SPE_POS = 7;
  localparam int STAT_BPH_POS = 3;
  localparam int STAT_BPL_POS = 2;
  localparam int STAT_WEL_POS = 1;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_WRITABLE = 8'hfc;
  // ************************************************************
  // array and protect boundaries (14-bit address)
  // ************************************************************
  localparam int ADDR_W = 14;
  localparam logic [13:0] QUARTER_BASE = 14'h3000;
  localparam logic [13:0] HALF_BASE = 14'h2000;
  localparam int OP_BITS = 8;
  localparam int ADDR_BITS = 16;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int WAKE_RECOVERY_TIME_US = 400;
  // longest time: rounds down
  localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAKE_CNT_W = 16;

  typedef enum logic [2:0] {
    CMD_OPCODE = 3'b000,
    CMD_ADDR = 3'b001,
    CMD_DATA = 3'b011,
    CMD_READ = 3'b010,
    CMD_DONE = 3'b110
  } smp_cmd_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_WAKE = 2'b11
  } smp_pwr_e;

  // synchronised link pins with edge events
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
  } smp_link_s;

  // write permission result
  typedef struct packed {
    logic mem_ok;
    logic stat_ok;
  } smp_perm_s;
endpackage

// >>> design/smp_sync.sv
// two-flop synchronisers and edge detection for the spi pins
// assumes pins are asynchronous to i_clock; cs and hold idle high
`timescale 1ns/10ps
`default_nettype none
module smp_sync (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // raw pins: cs_n, sck, si, hold_n, wp_n
  input wire logic [4:0] i_pins,
  // synchronised view
  output var smp_pkg::smp_link_s o_link
);
  // cs_n, hold_n and wp_n idle high, sck idles low: no false edge after reset
  localparam logic [4:0] IDLE = 5'b10011;
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic [4:0] prev_ff;

  // ************************************************************
  // synchroniser chain, per bit
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          meta_ff[g] <= IDLE[g];
          sync_ff[g] <= IDLE[g];
          prev_ff[g] <= IDLE[g];
        end else begin
          meta_ff[g] <= i_pins[g];
          sync_ff[g] <= meta_ff[g];
          prev_ff[g] <= sync_ff[g];
        end
      end
    end
  endgenerate

  always_comb begin
    o_link.cs_n = sync_ff[4];
    o_link.sck = sync_ff[3];
    o_link.si = sync_ff[2];
    o_link.hold_n = sync_ff[1];
    o_link.wp_n = sync_ff[0];
    o_link.cs_fall = prev_ff[4] & ~sync_ff[4];
    o_link.cs_rise = ~prev_ff[4] & sync_ff[4];
    o_link.sck_rise = ~prev_ff[3] & sync_ff[3];
    o_link.sck_fall = prev_ff[3] & ~sync_ff[3];
  end
endmodule
`default_nettype wire

// >>> sim/smp_ctrl_asserts.sv
// checker for smp_ctrl: protection, sleep and hold relations at the ports
// assumes bound onto smp_ctrl; wp pin held steady over each command
`timescale 1ns/10ps
`default_nettype none
module smp_ctrl_chk (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // pins
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic o_so_oe,
  // state
  input wire logic [13:0] o_mem_addr,
  input wire logic o_mem_we,
  input wire logic o_mem_re,
  input wire logic [7:0] o_status,
  input wire logic o_asleep,
  input wire logic o_held
);
  // ************************************************************
  // helpers and properties
  // ************************************************************
  logic [1:0] live_ff;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // masks the power-up load of the status image
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      live_ff <= 2'h0;
    end else if (live_ff != 2'h3) begin
      live_ff <= live_ff + 2'h1;
    end
  end
  sequence s_hold_req;
    $fell(i_hold_n) && !i_cs_n && !o_asleep;
  endsequence
  sequence s_hold_kept;
    (!i_hold_n && !i_cs_n) [*6];
  endsequence
  property p_hold_enter;
    s_hold_req ##1 s_hold_kept |-> o_held;
  endproperty
  property p_hold_quiet;
    o_held ##1 o_held |-> !o_so_oe && !o_mem_we && !o_mem_re;
  endproperty
  property p_perm_mem;
    o_mem_we |-> o_status[1] && !(o_status[3:2] == 2'h3
      || (o_status[3:2] == 2'h2 && o_mem_addr[13])
      || (o_status[3:2] == 2'h1 && o_mem_addr[13:12] == 2'h3));
  endproperty
  property p_stat_lock;
    live_ff == 2'h3 && $changed(o_status[7:2])
      |-> $past(o_status[1]) && !($past(o_status[7]) && !i_wp_n);
  endproperty
  property p_sleep_quiet;
    o_asleep |-> !o_so_oe && !o_mem_we && !o_mem_re;
  endproperty
  property p_sleep_entry;
    $rose(o_asleep) |-> i_cs_n;
  endproperty
  property p_wake_wel;
    $fell(o_asleep) |-> !o_status[1];
  endproperty
  property p_stat_bit0;
    live_ff == 2'h3 |-> o_status[0] == 1'b0;
  endproperty
  a_hold_enter: assert property (p_hold_enter)
    else $error("hold not entered");
  a_hold_quiet: assert property (p_hold_quiet)
    else $error("activity during hold");
  a_perm_mem: assert property (p_perm_mem)
    else $error("write to protected place");
  a_stat_lock: assert property (p_stat_lock)
    else $error("status changed while locked");
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("activity while asleep");
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep while selected");
  a_wake_wel: assert property (p_wake_wel)
    else $error("latch kept over wake");
  a_stat_bit0: assert property (p_stat_bit0)
    else $error("status bit0 set");
endmodule
bind smp_ctrl smp_ctrl_chk i_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_cs_n(i_cs_n),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so_oe(o_so_oe), .o_mem_addr(o_mem_addr),
  .o_mem_we(o_mem_we), .o_mem_re(o_mem_re), .o_status(o_status), .o_asleep(o_asleep),
  .o_held(o_held));
`default_nettype wire

// >>> sim/smp_ctrl_tb_top.sv
// self-checking bench for smp_ctrl against a small status model
// assumes smp_host drives the pins; array read data driven here
`timescale 1ns/10ps
`default_nettype none
module smp_ctrl_tb_top;
  // ************************************************************
  // wiring, model state, helpers
  // ************************************************************
  logic i_clock = 1'b0;
  logic i_rstn;
  logic cs_n, sck, si, hold_n, wp_n, so, so_oe, we, re, asleep, held, mwel;
  logic [7:0] nv, rdata, wdata, status, rx, seed, mst, cap_d;
  logic [13:0] maddr, cap_a, cap_r;
  logic [13:0] at [4] = '{14'h1fff, 14'h2000, 14'h2fff, 14'h3000};
  int errors, tests_run, we_cnt, re_cnt, cyc_cnt, n;
  always #4 i_clock = ~i_clock;
  smp_host i_host (.i_clock(i_clock), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .o_hold_n(hold_n), .o_wp_n(wp_n), .i_so(so), .i_so_oe(so_oe));
  smp_ctrl i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
    .i_nv_status(nv), .i_mem_rdata(rdata), .o_mem_addr(maddr), .o_mem_wdata(wdata),
    .o_mem_we(we), .o_mem_re(re), .o_status(status), .o_asleep(asleep), .o_held(held));
  always @(posedge i_clock) begin
    cyc_cnt++;
    if (we === 1'b1) begin
      we_cnt++;
      cap_a = maddr;
      cap_d = wdata;
    end
    if (re === 1'b1) begin
      if (re_cnt == 0) cap_r = maddr;
      re_cnt++;
    end
    if (cyc_cnt == 90000) begin
      errors++;
      end_sim();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [31:0] w, input int nb);
    i_host.sel();
    for (int k = 0; k < nb; k++) i_host.xfer(w[31-8*k -: 8], 8, rx);
    i_host.desel();
  endtask
  task automatic cmd(input logic [7:0] op);
    send({op, 24'h0}, 1);
    if (op == smp_pkg::OP_WREN) mwel = 1'b1;
    if (op == smp_pkg::OP_WRITE_DISABLE_COMMAND) mwel = 1'b0;
  endtask
  task automatic status_write_command(input logic [7:0] v);
    send({smp_pkg::OP_STATUS_WRITE_COMMAND, v, 16'h0}, 2);
    if (mwel && !(mst[7] && !wp_n)) mst = v & smp_pkg::STAT_WRITABLE;
    check(status, {mst[7:2], mwel, 1'b0});
  endtask
  task automatic wr_mem(input logic [13:0] a);
    logic ok;
    ok = mwel && !(mst[3:2] == 2'h3 || (mst[3:2] == 2'h2 && a[13])
      || (mst[3:2] == 2'h1 && a[13:12] == 2'h3));
    seed = lfsr(seed);
    we_cnt = 0;
    send({smp_pkg::OP_WRITE, 2'b00, a, seed}, 4);
    check(we_cnt, ok);
    if (ok) check({cap_a, cap_d}, {a, seed});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    i_rstn = 1'b0;
    seed = 8'h42;
    nv = lfsr(seed);
    rdata = 8'h00;
    repeat (4) @(posedge i_clock);
    i_rstn <= 1'b1;
    i_host.cyc(6);
    mst = nv & smp_pkg::STAT_WRITABLE;
    mwel = 1'b0;
    check(status, mst);
    $display("reset test done");
    for (int b = 3; b >= 0; b--) begin
      cmd(smp_pkg::OP_WREN);
      status_write_command({4'h0, b[1:0], 2'b00});
      for (int k = 0; k < 4; k++) wr_mem(at[k]);
    end
    cmd(smp_pkg::OP_WRITE_DISABLE_COMMAND);
    wr_mem(14'h0000);
    status_write_command(8'h0c);
    cmd(smp_pkg::OP_WREN);
    status_write_command(8'h80);
    i_host.o_wp_n <= 1'b0;
    status_write_command(8'h8c);
    i_host.o_wp_n <= 1'b1;
    status_write_command({1'b0, seed[6:4], 4'h0});
    $display("protect test done");
    i_host.sel();
    i_host.xfer(smp_pkg::OP_STATUS_READ_COMMAND, 8, rx);
    i_host.hold(1'b1);
    check({held, so_oe}, 2'b10);
    repeat (3) i_host.pulse();
    i_host.hold(1'b0);
    i_host.xfer(8'h00, 8, rx);
    i_host.desel();
    check(rx, {mst[7:2], mwel, 1'b0});
    i_host.sel();
    i_host.xfer(smp_pkg::OP_WRITE_DISABLE_COMMAND, 5, rx);
    i_host.hold(1'b1);
    i_host.desel();
    i_host.hold(1'b0);
    check({held, status[1]}, 2'b01);
    $display("hold test done");
    i_host.sel();
    i_host.xfer(smp_pkg::OP_SLEEP, 8, rx);
    i_host.pulse();
    i_host.desel();
    check(asleep, 1'b0);
    cmd(smp_pkg::OP_SLEEP);
    check({asleep, so_oe}, 2'b10);
    i_host.sel();
    i_host.desel();
    check(asleep, 1'b1);
    n = 0;
    // no reselect until the part is awake again
    while (asleep === 1'b1 && n < 60000) begin
      @(posedge i_clock);
      n++;
    end
    check(n <= smp_pkg::WAKE_RECOVERY_CYC, 1'b1);
    mwel = 1'b0;
    check(status, {mst[7:2], mwel, 1'b0});
    rdata <= lfsr(seed);
    re_cnt = 0;
    send({smp_pkg::OP_READ, 16'h0123, 8'h00}, 4);
    check(rx, rdata);
    check(cap_r, 14'h0123);
    $display("sleep test done");
    end_sim();
  end
endmodule
`default_nettype wire

// >>> sim/smp_host.sv
// spi host model driving the link pins, mode 0, 64 ns sck
// assumes i_clock at 8 ns; tasks are called from the bench top
`timescale 1ns/10ps
`default_nettype none
module smp_host (
  // clock
  input wire logic i_clock,
  // driven pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_hold_n,
  output logic o_wp_n,
  // returned data
  input wire logic i_so,
  input wire logic i_so_oe
);
  // ************************************************************
  // pin tasks
  // ************************************************************
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    o_wp_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic sel();
    o_cs_n <= 1'b0;
    cyc(4);
  endtask
  // sck stays low between frames; released si shows the inverse
  task automatic desel();
    cyc(4);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    cyc(8);
  endtask
  // low phase first: the previous task may have just lowered sck
  task automatic pulse();
    cyc(4);
    o_sck <= 1'b1;
    cyc(4);
    o_sck <= 1'b0;
  endtask
  // so sampled late in the high phase, before the fall can move it
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      o_si <= tx[i];
      cyc(4);
      o_sck <= 1'b1;
      cyc(4);
      rx[i] = i_so_oe ? i_so : 1'bx;
      o_sck <= 1'b0;
    end
  endtask
  // callers keep sck low, so release happens at the entry level
  task automatic hold(input logic on);
    o_hold_n <= ~on;
    cyc(8);
  endtask
endmodule
`default_nettype wire
